// >>> logic/irq_mask_pkg.sv
// shared constants and types for the usb dma interrupt mask logic
package irq_mask_pkg;

	// ************************************************************
	// bus geometry and responses
	// ************************************************************
	localparam int         ADDR_W      = 32;
	localparam int         DATA_W      = 32;
	localparam int         STRB_W      = DATA_W / 8;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ************************************************************
	// register byte addresses
	// ************************************************************
	localparam logic [ADDR_W-1:0] ADDR_PEND_STATUS = 32'h8004_0410;
	localparam logic [ADDR_W-1:0] ADDR_EN_SET      = 32'h8004_0418;
	localparam logic [ADDR_W-1:0] ADDR_EN_CLEAR    = 32'h8004_0420;
	localparam logic [ADDR_W-1:0] ADDR_PEND_FORCE  = 32'h8004_0428;
	localparam logic [ADDR_W-1:0] ADDR_PEND_ACK    = 32'h8004_0430;

	// ************************************************************
	// field positions, shared by all five registers
	// ************************************************************
	localparam int BIT_CH0_DONE  = 1;
	localparam int BIT_CH0_FAULT = 2;
	localparam int BIT_CH1_DONE  = 5;
	localparam int BIT_CH1_FAULT = 6;

	localparam logic [DATA_W-1:0] DONE_BITS  = 32'h0000_0022;
	localparam logic [DATA_W-1:0] FAULT_BITS = 32'h0000_0044;
	localparam logic [DATA_W-1:0] IRQ_BITS   = DONE_BITS | FAULT_BITS;
	localparam logic [DATA_W-1:0] FLAGS_RST  = 32'h0000_0000;
	localparam logic [DATA_W-1:0] ZERO_WORD  = 32'h0000_0000;

	// ************************************************************
	// types
	// ************************************************************
	// per-channel event lines from the dma channels, bit index = channel
	typedef struct packed {
		logic [1:0] transfer_done_event;
		logic [1:0] fault_event;
	} dma_evt_t;

	// per-channel flag enables from the channel control registers
	typedef struct packed {
		logic [1:0] done_flag_enable;
		logic [1:0] fault_flag_enable;
	} dma_flag_en_t;

	// a write held until both address and data have arrived
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
		logic [STRB_W-1:0] strb;
	} wr_req_t;

	typedef enum logic [1:0] {
		WR_IDLE = 2'h1,
		WR_RESP = 2'h2
	} wr_state_t;

	typedef enum logic [1:0] {
		RD_IDLE = 2'h1,
		RD_DATA = 2'h2
	} rd_state_t;

endpackage

// >>> logic/sticky_flags.sv
// bank of flags with independent set and clear vectors, set wins
`timescale 1ns/1ps
module sticky_flags
	import irq_mask_pkg::*;
#(
	parameter int                 W     = DATA_W,
	parameter logic [DATA_W-1:0]  RST_V = FLAGS_RST
) (
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic         ce,
	input  wire logic [W-1:0] set,
	input  wire logic [W-1:0] clr,
	output logic      [W-1:0] flags_q
);

	logic [W-1:0] flags_d;

	// an event landing in the clearing cycle is kept
	assign flags_d = (flags_q & ~clr) | set;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flags_q <= RST_V[W-1:0];
		end else if (ce) begin
			flags_q <= flags_d;
		end
	end

endmodule // sticky_flags

// >>> logic/usb_dma_irq_mask_logic.sv
// usb dma interrupt enable, pending and request logic behind an axi4-lite slave
//
// Notes on behaviour
// - writing one to an enable-set bit turns that interrupt on; zeros ignored
// - reading enable-set returns the current enable mask
// - writing one to an enable-clear bit turns that interrupt off; zeros ignored
// - reading enable-clear also returns the current enable mask
// - bits 1,2 are channel 0 done/fault, bits 5,6 channel 1; rest reserved
// - writing one to an ack bit clears that pending flag; zeros ignored
// - ack and force registers always read as zero
// - writing one to a force bit sets that pending flag
// - successful channel completion sets done flag when its flag enable is one
// - channel error abort sets fault flag when its flag enable is one
// - pending flags readable in a read-only status register, same positions
`timescale 1ns/1ps
module usb_dma_irq_mask_logic
	import irq_mask_pkg::*;
(
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic              ce,
	input  wire dma_evt_t          dma_evt,
	input  wire dma_flag_en_t      dma_flag_en,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [DATA_W-1:0] s_axi_wdata,
	input  wire logic [STRB_W-1:0] s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [DATA_W-1:0]      s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	output logic                   usb_dma_irq
);

	// ************************************************************
	// declarations
	// ************************************************************
	wr_state_t         wr_state_q;
	wr_state_t         wr_state_d;
	rd_state_t         rd_state_q;
	rd_state_t         rd_state_d;
	wr_req_t           wr_req_q;
	logic              aw_full_q;
	logic              aw_full_d;
	logic              w_full_q;
	logic              w_full_d;
	logic              awready_q;
	logic              wready_q;
	logic              bvalid_q;
	logic [1:0]        bresp_q;
	logic              arready_q;
	logic              rvalid_q;
	logic [DATA_W-1:0] rdata_q;
	logic [1:0]        rresp_q;
	logic              irq_q;
	logic [DATA_W-1:0] en_q;
	logic [DATA_W-1:0] pend_q;

	wire               aw_take;
	wire               w_take;
	wire               do_wr;
	wire               b_done;
	wire               ar_take;
	wire               r_done;
	wire [DATA_W-1:0]  strb_mask;
	wire [DATA_W-1:0]  wr_mask;
	wire               wr_hit_status;
	wire               wr_hit_en_set;
	wire               wr_hit_en_clr;
	wire               wr_hit_force;
	wire               wr_hit_ack;
	wire               wr_mapped;
	wire [DATA_W-1:0]  en_set;
	wire [DATA_W-1:0]  en_clr;
	wire [DATA_W-1:0]  pend_force;
	wire [DATA_W-1:0]  pend_ack;
	wire [DATA_W-1:0]  hw_set;
	wire [DATA_W-1:0]  pend_set;
	wire               rd_hit_status;
	wire               rd_hit_en;
	wire               rd_hit_wo;
	wire               rd_mapped;
	wire [DATA_W-1:0]  rd_word;
	wire               irq_now;

	// ************************************************************
	// write channel: address and data accepted in either order
	// ************************************************************
	// state is frozen while ce is low, so the master must not expect handshakes then
	assign aw_take = ce & s_axi_awvalid & awready_q;
	assign w_take  = ce & s_axi_wvalid & wready_q;
	assign do_wr   = ce & aw_full_q & w_full_q & (wr_state_q == WR_IDLE);
	assign b_done  = ce & bvalid_q & s_axi_bready;

	assign aw_full_d = aw_take | (aw_full_q & ~do_wr);
	assign w_full_d  = w_take | (w_full_q & ~do_wr);

	assign wr_state_d = do_wr  ? WR_RESP :
	                    b_done ? WR_IDLE : wr_state_q;

	assign strb_mask = {{8{wr_req_q.strb[3]}}, {8{wr_req_q.strb[2]}},
	                    {8{wr_req_q.strb[1]}}, {8{wr_req_q.strb[0]}}};
	// reserved bits are dropped here, whatever software writes there
	assign wr_mask   = wr_req_q.data & strb_mask & IRQ_BITS;

	assign wr_hit_status = (wr_req_q.addr == ADDR_PEND_STATUS);
	assign wr_hit_en_set = (wr_req_q.addr == ADDR_EN_SET);
	assign wr_hit_en_clr = (wr_req_q.addr == ADDR_EN_CLEAR);
	assign wr_hit_force  = (wr_req_q.addr == ADDR_PEND_FORCE);
	assign wr_hit_ack    = (wr_req_q.addr == ADDR_PEND_ACK);
	assign wr_mapped     = wr_hit_status | wr_hit_en_set | wr_hit_en_clr |
	                       wr_hit_force | wr_hit_ack;

	assign en_set     = (do_wr & wr_hit_en_set) ? wr_mask : ZERO_WORD;
	assign en_clr     = (do_wr & wr_hit_en_clr) ? wr_mask : ZERO_WORD;
	assign pend_force = (do_wr & wr_hit_force) ? wr_mask : ZERO_WORD;
	assign pend_ack   = (do_wr & wr_hit_ack) ? wr_mask : ZERO_WORD;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_state_q <= WR_IDLE;
			aw_full_q  <= 1'b0;
			w_full_q   <= 1'b0;
			awready_q  <= 1'b0;
			wready_q   <= 1'b0;
			wr_req_q   <= '0;
		end else if (ce) begin
			wr_state_q <= wr_state_d;
			aw_full_q  <= aw_full_d;
			w_full_q   <= w_full_d;
			awready_q  <= ~aw_full_d;
			wready_q   <= ~w_full_d;
			if (aw_take) begin
				wr_req_q.addr <= s_axi_awaddr;
			end
			if (w_take) begin
				wr_req_q.data <= s_axi_wdata;
				wr_req_q.strb <= s_axi_wstrb;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_q <= 1'b0;
			bresp_q  <= RESP_OKAY;
		end else if (ce) begin
			if (do_wr) begin
				bvalid_q <= 1'b1;
				bresp_q  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
			end else if (b_done) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// ************************************************************
	// read channel: one read at a time, data one cycle after address
	// ************************************************************
	assign ar_take = ce & s_axi_arvalid & arready_q;
	assign r_done  = ce & rvalid_q & s_axi_rready;

	assign rd_state_d = ar_take ? RD_DATA :
	                    r_done  ? RD_IDLE : rd_state_q;

	assign rd_hit_status = (s_axi_araddr == ADDR_PEND_STATUS);
	assign rd_hit_en     = (s_axi_araddr == ADDR_EN_SET) |
	                       (s_axi_araddr == ADDR_EN_CLEAR);
	assign rd_hit_wo     = (s_axi_araddr == ADDR_PEND_FORCE) |
	                       (s_axi_araddr == ADDR_PEND_ACK);
	assign rd_mapped     = rd_hit_status | rd_hit_en | rd_hit_wo;

	// both enable addresses show the mask, a one meaning enabled
	assign rd_word = rd_hit_status ? (pend_q & IRQ_BITS) :
	                 rd_hit_en     ? (en_q & IRQ_BITS) :
	                 ZERO_WORD;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_state_q <= RD_IDLE;
			arready_q  <= 1'b0;
			rvalid_q   <= 1'b0;
			rdata_q    <= ZERO_WORD;
			rresp_q    <= RESP_OKAY;
		end else if (ce) begin
			rd_state_q <= rd_state_d;
			arready_q  <= (rd_state_d == RD_IDLE);
			rvalid_q   <= (rd_state_d == RD_DATA);
			if (ar_take) begin
				rdata_q <= rd_word;
				rresp_q <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	// ************************************************************
	// enables, pending flags and the request line
	// ************************************************************
	assign hw_set = ({31'h0, dma_evt.transfer_done_event[0] &
	                  dma_flag_en.done_flag_enable[0]} << BIT_CH0_DONE) |
	                ({31'h0, dma_evt.transfer_done_event[1] &
	                  dma_flag_en.done_flag_enable[1]} << BIT_CH1_DONE) |
	                ({31'h0, dma_evt.fault_event[0] &
	                  dma_flag_en.fault_flag_enable[0]} << BIT_CH0_FAULT) |
	                ({31'h0, dma_evt.fault_event[1] &
	                  dma_flag_en.fault_flag_enable[1]} << BIT_CH1_FAULT);

	assign pend_set = hw_set | pend_force;

	sticky_flags #(
		.W     (DATA_W),
		.RST_V (FLAGS_RST)
	) u_enable (
		.aclk    (aclk),
		.aresetn (aresetn),
		.ce      (ce),
		.set     (en_set),
		.clr     (en_clr),
		.flags_q (en_q)
	);

	sticky_flags #(
		.W     (DATA_W),
		.RST_V (FLAGS_RST)
	) u_pending (
		.aclk    (aclk),
		.aresetn (aresetn),
		.ce      (ce),
		.set     (pend_set),
		.clr     (pend_ack),
		.flags_q (pend_q)
	);

	assign irq_now = |(pend_q & en_q & IRQ_BITS);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_q <= 1'b0;
		end else if (ce) begin
			irq_q <= irq_now;
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	assign s_axi_awready = awready_q;
	assign s_axi_wready  = wready_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;
	assign usb_dma_irq   = irq_q;

	// ************************************************************
	// assertions
	// ************************************************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_wr(logic [ADDR_W-1:0] a);
		do_wr && (wr_req_q.addr == a);
	endsequence

	sequence s_rd(logic [ADDR_W-1:0] a);
		ar_take && (s_axi_araddr == a);
	endsequence

	en_set_a: assert property (s_wr(ADDR_EN_SET) |=>
		en_q == ($past(en_q) | $past(wr_mask)))
		else $error("enable set write did not set exactly the written ones");

	en_rd_a: assert property (s_rd(ADDR_EN_SET) |=>
		rvalid_q && (rdata_q == ($past(en_q) & IRQ_BITS)))
		else $error("enable set read did not return the mask");

	en_clr_a: assert property (s_wr(ADDR_EN_CLEAR) |=>
		en_q == ($past(en_q) & ~$past(wr_mask)))
		else $error("enable clear write did not clear exactly the written ones");

	dis_rd_a: assert property (s_rd(ADDR_EN_CLEAR) |=>
		rdata_q == ($past(en_q) & IRQ_BITS))
		else $error("enable clear read did not return the mask");

	rsvd_zero_a: assert property ((en_q & ~IRQ_BITS) == ZERO_WORD &&
		(pend_q & ~IRQ_BITS) == ZERO_WORD && (!rvalid_q || (rdata_q & ~IRQ_BITS) == ZERO_WORD))
		else $error("reserved bit became set");

	ack_clr_a: assert property (s_wr(ADDR_PEND_ACK) |=>
		(pend_q & $past(wr_mask) & ~$past(hw_set)) == ZERO_WORD)
		else $error("ack write left a pending flag set");

	wo_read_a: assert property ((s_rd(ADDR_PEND_FORCE) or s_rd(ADDR_PEND_ACK)) |=>
		rvalid_q && rdata_q == ZERO_WORD && rresp_q == RESP_OKAY)
		else $error("write-only register read non-zero");

	force_set_a: assert property (s_wr(ADDR_PEND_FORCE) |=>
		(pend_q & $past(wr_mask)) == $past(wr_mask))
		else $error("force write did not set pending flag");

	done_evt_a: assert property (ce && (hw_set & DONE_BITS) != ZERO_WORD |=>
		(pend_q & $past(hw_set) & DONE_BITS) == ($past(hw_set) & DONE_BITS))
		else $error("done event lost");

	fault_evt_a: assert property (ce && (hw_set & FAULT_BITS) != ZERO_WORD |=>
		(pend_q & $past(hw_set) & FAULT_BITS) == ($past(hw_set) & FAULT_BITS))
		else $error("fault event lost");

	stat_rd_a: assert property (s_rd(ADDR_PEND_STATUS) |=>
		rdata_q == ($past(pend_q) & IRQ_BITS))
		else $error("status read did not return pending flags");

	irq_out_a: assert property (ce |=> usb_dma_irq == $past(irq_now))
		else $error("interrupt request does not follow pending and enable");

	// address and data taken together with no response pending: answer two edges later
	wr_resp_a: assert property (aw_take && w_take && wr_state_q == WR_IDLE ##1 ce |=>
		s_axi_bvalid)
		else $error("write response missing");

endmodule // usb_dma_irq_mask_logic

// >>> sim/test_usb_dma_irq_mask_logic.sv
// self-checking register-level bench for the usb dma interrupt mask logic
`timescale 1ns/1ps
module test_usb_dma_irq_mask_logic;
	import irq_mask_pkg::*;

	// ************************************************************
	// clock, reset and design ports
	// ************************************************************
	logic              aclk;
	logic              aresetn;
	logic              ce;
	dma_evt_t          dma_evt;
	dma_flag_en_t      dma_flag_en;
	logic [ADDR_W-1:0] s_axi_awaddr;
	logic              s_axi_awvalid;
	logic              s_axi_awready;
	logic [DATA_W-1:0] s_axi_wdata;
	logic [STRB_W-1:0] s_axi_wstrb;
	logic              s_axi_wvalid;
	logic              s_axi_wready;
	logic [1:0]        s_axi_bresp;
	logic              s_axi_bvalid;
	logic              s_axi_bready;
	logic [ADDR_W-1:0] s_axi_araddr;
	logic              s_axi_arvalid;
	logic              s_axi_arready;
	logic [DATA_W-1:0] s_axi_rdata;
	logic [1:0]        s_axi_rresp;
	logic              s_axi_rvalid;
	logic              s_axi_rready;
	logic              usb_dma_irq;
	int                failures;
	int                checked;
	int                pos [4];
	logic [DATA_W-1:0] m;

	initial aclk = 1'b0;
	always #5 aclk = ~aclk;

	usb_dma_irq_mask_logic i_usb_dma_irq_mask_logic (
		.aclk          (aclk),
		.aresetn       (aresetn),
		.ce            (ce),
		.dma_evt       (dma_evt),
		.dma_flag_en   (dma_flag_en),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.usb_dma_irq   (usb_dma_irq)
	);

	// ************************************************************
	// compare, bus tasks and closing
	// ************************************************************
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic end_sim();
		$display("checks %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// bready stays up until the response is seen; one idle edge keeps drivers from double assigning
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic [1:0] er);
		logic done;
		done = 1'b0;
		s_axi_awaddr  <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata   <= d;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		// no cycle limit here: only the watchdog ends a wait
		while (!done) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid && s_axi_bready) begin
				check("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
				done = 1'b1;
			end
		end
		s_axi_bready <= 1'b0;
		@(posedge aclk);
		check("bvalid drop", {31'h0, s_axi_bvalid}, 32'h0);
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e, input logic [1:0] er);
		logic done;
		done = 1'b0;
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		while (!done) begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid && s_axi_rready) begin
				check("rdata", s_axi_rdata, e);
				check("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
				done = 1'b1;
			end
		end
		s_axi_rready <= 1'b0;
		@(posedge aclk);
		check("rvalid drop", {31'h0, s_axi_rvalid}, 32'h0);
	endtask

	// one cycle of event lines, then quiet again
	task automatic pulse(input dma_evt_t ev);
		dma_evt <= ev;
		@(posedge aclk);
		dma_evt <= '0;
		@(posedge aclk);
	endtask

	// ************************************************************
	// watchdog
	// ************************************************************
	initial begin
		repeat (20000) @(posedge aclk);
		failures++;
		end_sim();
	end

	// ************************************************************
	// tests
	// ************************************************************
	initial begin
		failures = 0;
		checked = 0;
		pos = '{BIT_CH0_DONE, BIT_CH0_FAULT, BIT_CH1_DONE, BIT_CH1_FAULT};
		aresetn = 1'b0;
		ce = 1'b1;
		dma_evt = '0;
		dma_flag_en = '0;
		s_axi_awaddr = '0;
		s_axi_awvalid = 1'b0;
		s_axi_wdata = '0;
		s_axi_wstrb = 4'hf;
		s_axi_wvalid = 1'b0;
		s_axi_bready = 1'b0;
		s_axi_araddr = '0;
		s_axi_arvalid = 1'b0;
		s_axi_rready = 1'b0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		check("irq after reset", {31'h0, usb_dma_irq}, 32'h0);
		rd(ADDR_EN_SET, ZERO_WORD, RESP_OKAY);
		rd(ADDR_PEND_STATUS, ZERO_WORD, RESP_OKAY);
		// each live bit alone: enable, force, mask, unmask, acknowledge
		for (int k = 0; k < 4; k++) begin
			m = 32'h0000_0001 << pos[k];
			wr(ADDR_EN_SET, m, RESP_OKAY);
			rd(ADDR_EN_SET, m, RESP_OKAY);
			rd(ADDR_EN_CLEAR, m, RESP_OKAY);
			wr(ADDR_PEND_FORCE, m, RESP_OKAY);
			rd(ADDR_PEND_STATUS, m, RESP_OKAY);
			check("irq forced", {31'h0, usb_dma_irq}, 32'h1);
			wr(ADDR_EN_CLEAR, m, RESP_OKAY);
			check("irq masked", {31'h0, usb_dma_irq}, 32'h0);
			rd(ADDR_PEND_STATUS, m, RESP_OKAY);
			wr(ADDR_EN_SET, m, RESP_OKAY);
			wr(ADDR_PEND_ACK, m, RESP_OKAY);
			rd(ADDR_PEND_STATUS, ZERO_WORD, RESP_OKAY);
			check("irq acked", {31'h0, usb_dma_irq}, 32'h0);
			wr(ADDR_EN_CLEAR, m, RESP_OKAY);
		end
		// zeros in a written word leave other bits alone
		wr(ADDR_EN_SET, IRQ_BITS, RESP_OKAY);
		wr(ADDR_EN_CLEAR, 32'h0000_0002, RESP_OKAY);
		wr(ADDR_EN_SET, ZERO_WORD, RESP_OKAY);
		rd(ADDR_EN_CLEAR, 32'h0000_0064, RESP_OKAY);
		wr(ADDR_PEND_FORCE, DONE_BITS, RESP_OKAY);
		wr(ADDR_PEND_ACK, 32'h0000_0020, RESP_OKAY);
		rd(ADDR_PEND_STATUS, 32'h0000_0002, RESP_OKAY);
		check("irq masked done", {31'h0, usb_dma_irq}, 32'h0);
		rd(ADDR_PEND_FORCE, ZERO_WORD, RESP_OKAY);
		rd(ADDR_PEND_ACK, ZERO_WORD, RESP_OKAY);
		wr(ADDR_PEND_ACK, IRQ_BITS, RESP_OKAY);
		// channel events only count while their flag enable is on
		pulse('{transfer_done_event: 2'h3, fault_event: 2'h3});
		rd(ADDR_PEND_STATUS, ZERO_WORD, RESP_OKAY);
		dma_flag_en <= '{done_flag_enable: 2'h2, fault_flag_enable: 2'h1};
		@(posedge aclk);
		pulse('{transfer_done_event: 2'h3, fault_event: 2'h3});
		rd(ADDR_PEND_STATUS, 32'h0000_0024, RESP_OKAY);
		check("irq from event", {31'h0, usb_dma_irq}, 32'h1);
		// status is read-only, unmapped places answer with an error
		wr(ADDR_PEND_STATUS, IRQ_BITS, RESP_OKAY);
		rd(ADDR_PEND_STATUS, 32'h0000_0024, RESP_OKAY);
		wr(32'h8004_0400, IRQ_BITS, RESP_SLVERR);
		rd(32'h8004_0400, ZERO_WORD, RESP_SLVERR);
		wr(ADDR_PEND_ACK, 32'h0000_0004, RESP_OKAY);
		check("irq one left", {31'h0, usb_dma_irq}, 32'h1);
		wr(ADDR_PEND_ACK, 32'h0000_0020, RESP_OKAY);
		check("irq after ack", {31'h0, usb_dma_irq}, 32'h0);
		// all live bits sit in byte lane 0, so a write without that lane does nothing
		s_axi_wstrb <= 4'he;
		wr(ADDR_PEND_FORCE, IRQ_BITS, RESP_OKAY);
		s_axi_wstrb <= 4'hf;
		// events seen while ce is low are not taken
		ce <= 1'b0;
		pulse('{transfer_done_event: 2'h2, fault_event: 2'h1});
		ce <= 1'b1;
		rd(ADDR_PEND_STATUS, ZERO_WORD, RESP_OKAY);
		check("irq held low", {31'h0, usb_dma_irq}, 32'h0);
		end_sim();
	end

endmodule // test_usb_dma_irq_mask_logic
